//--- bench/otfs_plant.sv
// power stage, programming resistor and supply rail model
`timescale 1ns/1ps
`include "otfs_regs.svh"

module otfs_plant (
	// clock
	input  wire logic       clock_in,
	// resistor choice from the bench
	input  wire logic [3:0] res_code_in,
	// device controls
	input  wire logic       probe_enable_in,
	input  wire logic       discharge_in,
	input  wire logic       hv_on_in,
	// sensed back to the device
	output logic [7:0]      probe_current_out,
	output logic            upper_out,
	output logic            lower_out,
	output logic            disch_level_out
);
	int         rail = 40;
	logic [7:0] junk = 8'h5a;
	// probe currents sit well inside each interval, open is lowest
	logic [7:0] tbl [9] = '{8'h0c, `OTFS_PB1 + 8'h08, `OTFS_PB2 + 8'h08,
		`OTFS_PB3 + 8'h08, `OTFS_PB4 + 8'h08, `OTFS_PB5 + 8'h08,
		`OTFS_PB6 + 8'h08, `OTFS_PB7 + 8'h08, `OTFS_PB8 + 8'h08};

	// rail: source charges, discharge pulls hard, else slow sag
	always @(posedge clock_in) begin
		junk <= {junk[6:0], ~junk[7]};
		if (discharge_in)
			rail <= (rail > 1) ? rail - 2 : 0;
		else if (hv_on_in)
			rail <= (rail < 63) ? rail + 1 : 63;
		else
			rail <= (rail > 0) ? rail - 1 : 0;
	end

	// probe current only
	// no stale value outside the probe: a changing pattern instead
	assign probe_current_out = probe_enable_in ? tbl[res_code_in] : junk;
	assign upper_out         = rail >= 48;
	assign lower_out         = rail <= 16;
	assign disch_level_out   = rail <= 8;
endmodule

//--- bench/testbench.sv
// self-checking bench of the overload timer and fault sequencer
`timescale 1ns/1ps

module testbench;
	logic        clock_in = 0;
	logic        sys_rst_in = 1;
	logic [11:0] cur = 0;
	logic        tick = 0;
	logic [6:0]  flt = 0;
	logic        pin_flt = 0;
	logic        line = 0;
	logic        has_tmr = 0;
	logic        latv = 0;
	logic [3:0]  res = 0;
	logic        rnd_on = 1;
	logic [7:0]  probe_i;
	logic        up, lo, dl;
	logic        gate, prb, lp, dis, hv, lat, hv_q;
	logic [3:0]  code;
	logic [6:0]  pct;
	logic [23:0] lvl, hold;
	logic [31:0] seed = 32'hda36_14f7;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n, bad, tog;

	otfs_top #(.FILT_CYC(20), .TICK_B(3), .TICK_C(2),
		.OFF_LONG(50), .OFF_SHORT(20)) i_otfs_top (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.cc_current_est_in(cur), .pwm_period_tick_in(tick),
		.supply_ovp_in(flt[0]), .supply_uv_in(flt[1]),
		.over_temp_in(flt[2]), .shutdown_low_in(flt[3]),
		.output_ov_in(flt[4]), .line_uv_in(flt[5]),
		.xcap_discharge_in(flt[6]), .pin_fault_in(pin_flt),
		.line_present_in(line), .latch_upper_level_in(up),
		.latch_lower_level_in(lo), .supply_discharge_level_in(dl),
		.probe_current_in(probe_i), .has_overload_timer_in(has_tmr),
		.latching_variant_in(latv), .gate_drive_pin_en_out(gate),
		.probe_enable_out(prb), .low_power_out(lp),
		.supply_discharge_out(dis), .hv_source_on_out(hv),
		.fault_latched_out(lat), .program_resistor_code_out(code),
		.cc_limit_pct_out(pct), .timer_level_out(lvl));

	otfs_plant i_otfs_plant (
		.clock_in(clock_in), .res_code_in(res),
		.probe_enable_in(prb), .discharge_in(dis), .hv_on_in(hv),
		.probe_current_out(probe_i), .upper_out(up), .lower_out(lo),
		.disch_level_out(dl));

	// 200 MHz clock
	initial begin
		forever #2.5 clock_in = ~clock_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// model: limit percent and trip level by code
	function automatic int exp_pct(input int k);
		int t [9] = '{100, 90, 80, 75, 70, 65, 60, 55, 50};
		return t[k];
	endfunction

	function automatic int trip(input int k);
		int t [3] = '{160, 135, 110};
		return 1024 * 1024 * t[k / 3] / 100;
	endfunction

	function automatic logic pick(input int s);
		case (s)
			0: return gate;
			1: return prb;
			2: return lp;
			3: return dis;
			default: return lat;
		endcase
	endfunction

	task automatic final_report();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge clock_in);
		#1;
	endtask

	// bounded wait for a control output, n holds cycles taken
	task automatic wait_on(input int s, input logic v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			step(1);
			n++;
		end
	endtask

	// fault until drive drops, filter time checked, then off time
	task automatic trip_on(input int f, input int off);
		flt[f] = 1;
		wait_on(0, 0, 40);
		check(n >= 20 && n < 30, 1);
		flt[f] = 0;
		wait_on(3, 1, 100);
		check(n >= off - 4 && n <= off + 2, 1);
	endtask

	// random load and period tick, one small delay after each edge
	always @(posedge clock_in) begin
		#1;
		seed = xs(seed);
		tick = (cycles % 4) == 0;
		if (rnd_on)
			cur = seed[11:0] & 12'h3ff;
		cycles++;
		if (cycles >= 100000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		step(12);
		check({gate, prb, lp, lat}, 0);
		check(pct, 32'h64);
		sys_rst_in = 0;
		line = 1;
		// every code, every filtered fault, restart each time
		for (int k = 0; k <= 8; k++) begin
			wait_on(1, 1, 200);
			check(gate, 0);
			wait_on(0, 1, 2200);
			check(n < 2200, 1);
			step(3);
			check(code, k);
			check(pct, exp_pct(k));
			res = 4'((k + 1) % 9);
			step(40);
			check(code, k);
			flt[k % 7] = 1;
			step(10);
			flt[k % 7] = 0;
			step(12);
			check(gate, 1);
			trip_on(k % 7, (k % 7 >= 5) ? 20 : 50);
		end
		$display("decode and filtered faults done");
		// start-up pin fault, auto variant: no drive, hiccup
		pin_flt = 1;
		wait_on(1, 1, 200);
		wait_on(1, 0, 2200);
		step(2);
		check({gate, lp, lat}, 3'b010);
		wait_on(3, 1, 100);
		check(n >= 46 && n <= 52, 1);
		wait_on(1, 1, 200);
		check(n < 200, 1);
		pin_flt = 0;
		wait_on(0, 1, 2200);
		check(n < 2200, 1);
		$display("auto start-up fault done");
		// latching variant: held supply, no restart
		latv = 1;
		pin_flt = 1;
		trip_on(6, 20);
		wait_on(4, 1, 2300);
		check(n < 2300, 1);
		bad = 0;
		tog = 0;
		hv_q = hv;
		repeat (400) begin
			step(1);
			bad += (gate !== 0 || lat !== 1);
			tog += (hv !== hv_q);
			hv_q = hv;
		end
		check(bad, 0);
		check(tog >= 4, 1);
		line = 0;
		wait_on(4, 0, 20);
		check(n < 20, 1);
		pin_flt = 0;
		latv = 0;
		line = 1;
		wait_on(0, 1, 2300);
		check(n < 2300, 1);
		$display("latched fault done");
		// overload timer variant, shortest constant, lowest trip
		has_tmr = 1;
		res = 8;
		rnd_on = 0;
		step(1);
		cur = 12'd1024;
		trip_on(5, 20);
		wait_on(0, 1, 2300);
		step(3);
		check(code, 8);
		check(pct, 32'h64);
		hold = lvl;
		step(200);
		check(lvl > hold && gate === 1, 1);
		cur = 12'hfff;
		wait_on(0, 0, 2000);
		check(n < 2000, 1);
		check(lvl >= trip(8) && lp === 1, 1);
		hold = lvl;
		cur = 0;
		wait_on(3, 1, 100);
		check(n >= 46 && n <= 52, 1);
		check(lvl < hold, 1);
		$display("overload timer done");
		final_report();
	end
endmodule

//--- verilog/otfs_persist.sv
// persistence filter for one fault line
`timescale 1ns/1ps
`include "otfs_regs.svh"

module otfs_persist #(
	parameter int unsigned FILT_CYC = `OTFS_FILT_CYC
) (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	// fault and switching period
	input  wire logic fault_in,
	input  wire logic period_tick_in,
	// filtered fault
	output logic      fault_out
);
	logic [31:0] cyc_cnt;
	logic [1:0]  per_cnt;

	// both counts restart on any gap so glitches never pass
	// longer of time or periods
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cyc_cnt <= 32'h0000_0000;
			per_cnt <= 2'h0;
		end else if (!fault_in) begin
			cyc_cnt <= 32'h0000_0000;
			per_cnt <= 2'h0;
		end else begin
			if (cyc_cnt < FILT_CYC)
				cyc_cnt <= cyc_cnt + 32'h0000_0001;
			if (period_tick_in && per_cnt < `OTFS_FILT_PERIODS)
				per_cnt <= per_cnt + 2'h1;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			fault_out <= 1'b0;
		else
			fault_out <= fault_in && cyc_cnt >= FILT_CYC
				&& per_cnt >= `OTFS_FILT_PERIODS;
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	glitch_blocked_a: assert property (!fault_in |=> !fault_out)
		else $error("filtered fault passed without input");
	two_periods_a: assert property ($rose(fault_out) |->
		$past(per_cnt) == `OTFS_FILT_PERIODS)
		else $error("fault passed before two periods");
endmodule

//--- verilog/otfs_pkg.sv
// types of the overload timer and fault sequencer
package otfs_pkg;

	// sequencer states
	typedef enum logic [2:0] {
		OTFS_IDLE,
		OTFS_PROBE,
		OTFS_RUN,
		OTFS_OFF,
		OTFS_DISCH,
		OTFS_LATCH
	} otfs_state_t;

	// resistor code, 0 is open
	typedef logic [3:0] otfs_code_t;

endpackage

//--- verilog/otfs_regs.svh
// constants of the overload timer and fault sequencer
//
// Functional notes
// - timer uses the same current estimate as the current-limit loop
// - timer trip stops drive, long low-power wait, discharge, restart
// - timer input is the squared current estimate times a fixed gain
// - timer always runs; steps follow input minus level, settling exponentially
// - timer never resets when regulation mode changes
// - trip level 160/135/110 percent, time constant 1000/500/150 ms
// - nine resistor codes map to trip and time constant pairs
// - before switching, probe the drive pin and classify the current
// - variants without timer map the codes to current-limit percentages
// - faults stop the drive only after persisting their filter delay
// - a fault present at start-up prevents any switching
// - auto-restart: long or short low-power wait, discharge, restart
// - repeat the restart cycle while the fault stays, resume after
// - latched fault: no restart, high-voltage source holds supply window
// - line loss while latched resets; start normally when line returns
// - supply over-voltage stops drive and enters fault handling
// - feedback pin open or short at start-up gives no drive pulses
// - filter delay is 125 us or two switching periods, longer one
// - start-up pin faults act with no persistence filter
`ifndef OTFS_REGS_SVH
`define OTFS_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OTFS_CLK_MHZ      200
`define OTFS_FILT_US      125
`define OTFS_FILT_CYC     (`OTFS_FILT_US * `OTFS_CLK_MHZ)
`define OTFS_FILT_PERIODS 2'h2
`define OTFS_PROBE_US     10
`define OTFS_PROBE_CYC    32'(`OTFS_PROBE_US * `OTFS_CLK_MHZ)
`define OTFS_OFF_LONG_MS  1000
`define OTFS_OFF_SHORT_MS 100
`define OTFS_MS_CYC(ms)   ((ms) * 1000 * `OTFS_CLK_MHZ)

// ----------------------------------------------------------------
// overload timer: level steps by (input - level) / 2^shift per tick
// ----------------------------------------------------------------
`define OTFS_TAU_SHIFT    10
`define OTFS_TAU_A_MS     1000
`define OTFS_TAU_B_MS     500
`define OTFS_TAU_C_MS     150
`define OTFS_TICK_CYC(ms) (`OTFS_MS_CYC(ms) >> `OTFS_TAU_SHIFT)
`define OTFS_I_RATED      24'h00_0400
`define OTFS_P_RATED      (`OTFS_I_RATED * `OTFS_I_RATED)
`define OTFS_TRIP_A       24'(`OTFS_P_RATED * 160 / 100)
`define OTFS_TRIP_B       24'(`OTFS_P_RATED * 135 / 100)
`define OTFS_TRIP_C       24'(`OTFS_P_RATED * 110 / 100)
`define OTFS_GAIN_K       24'h00_0001

// ----------------------------------------------------------------
// probe current boundaries, 0.5 uA per count, rising current
// ----------------------------------------------------------------
`define OTFS_PB1 8'h1c
`define OTFS_PB2 8'h34
`define OTFS_PB3 8'h4a
`define OTFS_PB4 8'h62
`define OTFS_PB5 8'h78
`define OTFS_PB6 8'h90
`define OTFS_PB7 8'ha8
`define OTFS_PB8 8'hc0

// ----------------------------------------------------------------
// current-limit percentages by code
// ----------------------------------------------------------------
`define OTFS_CC0 7'h64
`define OTFS_CC1 7'h5a
`define OTFS_CC2 7'h50
`define OTFS_CC3 7'h4b
`define OTFS_CC4 7'h46
`define OTFS_CC5 7'h41
`define OTFS_CC6 7'h3c
`define OTFS_CC7 7'h37
`define OTFS_CC8 7'h32

// ----------------------------------------------------------------
// synchronised input vector bit positions
// ----------------------------------------------------------------
`define OTFS_B_OVP    0
`define OTFS_B_UV     1
`define OTFS_B_OT     2
`define OTFS_B_SD     3
`define OTFS_B_OOV    4
`define OTFS_B_LUV    5
`define OTFS_B_XCAP   6
`define OTFS_B_PIN    7
`define OTFS_B_LINE   8
`define OTFS_B_LHI    9
`define OTFS_B_LLO    10
`define OTFS_B_DIS    11
`define OTFS_B_HASTMR 12
`define OTFS_B_LATVAR 13
`define OTFS_NSYNC    14
`define OTFS_NFILT    7

`endif

//--- verilog/otfs_top.sv
// overload timer, resistor decode and fault sequencer
`timescale 1ns/1ps
`include "otfs_regs.svh"

module otfs_top #(
	parameter int unsigned FILT_CYC  = `OTFS_FILT_CYC,
	parameter int unsigned TICK_A    = `OTFS_TICK_CYC(`OTFS_TAU_A_MS),
	parameter int unsigned TICK_B    = `OTFS_TICK_CYC(`OTFS_TAU_B_MS),
	parameter int unsigned TICK_C    = `OTFS_TICK_CYC(`OTFS_TAU_C_MS),
	parameter int unsigned OFF_LONG  = `OTFS_MS_CYC(`OTFS_OFF_LONG_MS),
	parameter int unsigned OFF_SHORT = `OTFS_MS_CYC(`OTFS_OFF_SHORT_MS)
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// current estimate from the current-limit loop, same clock
	input  wire logic [11:0] cc_current_est_in,
	input  wire logic        pwm_period_tick_in,
	// analogue comparators and pin checks
	input  wire logic        supply_ovp_in,
	input  wire logic        supply_uv_in,
	input  wire logic        over_temp_in,
	input  wire logic        shutdown_low_in,
	input  wire logic        output_ov_in,
	input  wire logic        line_uv_in,
	input  wire logic        xcap_discharge_in,
	input  wire logic        pin_fault_in,
	input  wire logic        line_present_in,
	input  wire logic        latch_upper_level_in,
	input  wire logic        latch_lower_level_in,
	input  wire logic        supply_discharge_level_in,
	input  wire logic [7:0]  probe_current_in,
	// variant straps
	input  wire logic        has_overload_timer_in,
	input  wire logic        latching_variant_in,
	// power stage controls
	output logic             gate_drive_pin_en_out,
	output logic             probe_enable_out,
	output logic             low_power_out,
	output logic             supply_discharge_out,
	output logic             hv_source_on_out,
	// status
	output logic             fault_latched_out,
	output logic [3:0]       program_resistor_code_out,
	output logic [6:0]       cc_limit_pct_out,
	output logic [23:0]      timer_level_out
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [`OTFS_NSYNC-1:0] sync1;
	logic [`OTFS_NSYNC-1:0] sync2;
	logic [7:0]             prb1;
	logic [7:0]             prb2;
	// pins are asynchronous to clock_in, two flops each
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1 <= '0;
			sync2 <= '0;
			prb1  <= 8'h00;
			prb2  <= 8'h00;
		end else begin
			sync1 <= {latching_variant_in, has_overload_timer_in,
				supply_discharge_level_in, latch_lower_level_in,
				latch_upper_level_in, line_present_in, pin_fault_in,
				xcap_discharge_in, line_uv_in, output_ov_in,
				shutdown_low_in, over_temp_in, supply_uv_in,
				supply_ovp_in};
			sync2 <= sync1;
			prb1  <= probe_current_in;
			prb2  <= prb1;
		end
	end

	// ----------------------------------------------------------------
	// persistence filters
	// ----------------------------------------------------------------
	logic [`OTFS_NFILT-1:0] filt;
	for (genvar i = 0; i < `OTFS_NFILT; i++) begin : g_filt
		otfs_persist #(.FILT_CYC(FILT_CYC)) u_persist (
			.clock_in       (clock_in),
			.sys_rst_in     (sys_rst_in),
			.fault_in       (sync2[i]),
			.period_tick_in (pwm_period_tick_in),
			.fault_out      (filt[i])
		);
	end

	// ----------------------------------------------------------------
	// settings and straps
	// ----------------------------------------------------------------
	otfs_pkg::otfs_state_t state;
	otfs_pkg::otfs_state_t next_state;
	otfs_pkg::otfs_code_t  code;
	otfs_pkg::otfs_code_t  next_code;
	logic                  has_timer;
	logic                  latch_var;
	logic [31:0]           cnt;
	logic                  probe_done;
	assign probe_done = state == otfs_pkg::OTFS_PROBE
		&& cnt == `OTFS_PROBE_CYC - 32'h0000_0001;
	// classify probe current, higher current is lower resistance
	always_comb begin
		if (prb2 >= `OTFS_PB8)      next_code = 4'h8;
		else if (prb2 >= `OTFS_PB7) next_code = 4'h7;
		else if (prb2 >= `OTFS_PB6) next_code = 4'h6;
		else if (prb2 >= `OTFS_PB5) next_code = 4'h5;
		else if (prb2 >= `OTFS_PB4) next_code = 4'h4;
		else if (prb2 >= `OTFS_PB3) next_code = 4'h3;
		else if (prb2 >= `OTFS_PB2) next_code = 4'h2;
		else if (prb2 >= `OTFS_PB1) next_code = 4'h1;
		else                        next_code = 4'h0;
	end
	// capture once per start-up, straps caught after release
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			code      <= 4'h0;
			has_timer <= 1'b0;
			latch_var <= 1'b0;
		end else if (probe_done) begin
			code      <= next_code;
			has_timer <= sync2[`OTFS_B_HASTMR];
			latch_var <= sync2[`OTFS_B_LATVAR];
		end
	end
	// current-limit percentage; timer variants run at full limit
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cc_limit_pct_out <= `OTFS_CC0;
		else if (has_timer)
			cc_limit_pct_out <= `OTFS_CC0;
		else
			case (code)
				4'h1:    cc_limit_pct_out <= `OTFS_CC1;
				4'h2:    cc_limit_pct_out <= `OTFS_CC2;
				4'h3:    cc_limit_pct_out <= `OTFS_CC3;
				4'h4:    cc_limit_pct_out <= `OTFS_CC4;
				4'h5:    cc_limit_pct_out <= `OTFS_CC5;
				4'h6:    cc_limit_pct_out <= `OTFS_CC6;
				4'h7:    cc_limit_pct_out <= `OTFS_CC7;
				4'h8:    cc_limit_pct_out <= `OTFS_CC8;
				default: cc_limit_pct_out <= `OTFS_CC0;
			endcase
	end

	// ----------------------------------------------------------------
	// overload timer
	// ----------------------------------------------------------------
	logic [33:0] acc;
	logic [23:0] sq_in;
	logic [23:0] level;
	logic [23:0] trip_thr;
	logic [31:0] tick_len;
	logic [31:0] tick_cnt;
	logic        tick;
	logic        ovl_trip;
	// code / 3 picks trip, code mod 3 picks time constant
	always_comb begin
		if (code >= 4'h6)      trip_thr = `OTFS_TRIP_C;
		else if (code >= 4'h3) trip_thr = `OTFS_TRIP_B;
		else                   trip_thr = `OTFS_TRIP_A;
		case (code)
			4'h1, 4'h4, 4'h7: tick_len = TICK_B;
			4'h2, 4'h5, 4'h8: tick_len = TICK_C;
			default:          tick_len = TICK_A;
		endcase
	end
	assign sq_in = 24'(cc_current_est_in * cc_current_est_in) * `OTFS_GAIN_K;
	assign level = acc[33:`OTFS_TAU_SHIFT];
	assign tick  = tick_cnt >= tick_len - 32'h0000_0001;
	// step rate sets the time constant, shift sets the step fraction
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tick_cnt <= 32'h0000_0000;
		else if (tick)
			tick_cnt <= 32'h0000_0000;
		else
			tick_cnt <= tick_cnt + 32'h0000_0001;
	end
	// leaky integrator, never cleared by mode or fault
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			acc <= 34'h0_0000_0000;
		else if (tick)
			acc <= acc + {10'h000, sq_in} - (acc >> `OTFS_TAU_SHIFT);
	end
	assign ovl_trip = has_timer && level >= trip_thr;

	// ----------------------------------------------------------------
	// fault sequencer
	// ----------------------------------------------------------------
	logic long_f;
	logic short_f;
	logic latch_f;
	logic raw_f;
	logic hv_hold;
	logic short_sel;
	logic next_short;
	// latching classes depend on the variant strap
	assign latch_f = latch_var && (filt[`OTFS_B_OVP] || filt[`OTFS_B_OT]
		|| filt[`OTFS_B_SD] || filt[`OTFS_B_OOV]);
	// supply over-voltage joins the long class
	assign long_f  = |filt[`OTFS_B_OOV:`OTFS_B_OVP] || ovl_trip;
	assign short_f = filt[`OTFS_B_LUV] || filt[`OTFS_B_XCAP];
	// unfiltered view while probing, before any switching
	assign raw_f   = |sync2[`OTFS_B_XCAP:`OTFS_B_OVP];
	// next state
	always_comb begin
		next_state = state;
		next_short = short_sel;
		case (state)
			otfs_pkg::OTFS_IDLE:
				if (sync2[`OTFS_B_LINE])
					next_state = otfs_pkg::OTFS_PROBE;
			otfs_pkg::OTFS_PROBE:
				// pin check acts at once, no filter
				if (probe_done && sync2[`OTFS_B_PIN]) begin
					next_state = sync2[`OTFS_B_LATVAR] ?
						otfs_pkg::OTFS_LATCH : otfs_pkg::OTFS_OFF;
					next_short = 1'b0;
				end else if (probe_done && raw_f) begin
					next_state = otfs_pkg::OTFS_OFF;
					next_short = 1'b0;
				end else if (probe_done)
					next_state = otfs_pkg::OTFS_RUN;
			otfs_pkg::OTFS_RUN:
				// filtered faults and timer trip stop drive
				if (latch_f)
					next_state = otfs_pkg::OTFS_LATCH;
				else if (long_f) begin
					next_state = otfs_pkg::OTFS_OFF;
					next_short = 1'b0;
				end else if (short_f) begin
					next_state = otfs_pkg::OTFS_OFF;
					next_short = 1'b1;
				end
			otfs_pkg::OTFS_OFF:
				if (cnt >= (short_sel ? OFF_SHORT : OFF_LONG)
					- 32'h0000_0001)
					next_state = otfs_pkg::OTFS_DISCH;
			otfs_pkg::OTFS_DISCH:
				// restart re-probes, so a lasting fault loops
				if (sync2[`OTFS_B_DIS])
					next_state = otfs_pkg::OTFS_PROBE;
			otfs_pkg::OTFS_LATCH:
				if (!sync2[`OTFS_B_LINE])
					next_state = otfs_pkg::OTFS_IDLE;
			default:
				next_state = otfs_pkg::OTFS_IDLE;
		endcase
	end
	// state and phase counter
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state     <= otfs_pkg::OTFS_IDLE;
			short_sel <= 1'b0;
			cnt       <= 32'h0000_0000;
		end else begin
			state     <= next_state;
			short_sel <= next_short;
			cnt       <= next_state != state ? 32'h0000_0000
				: cnt + 32'h0000_0001;
		end
	end
	// hold supply between latch levels with the hv source
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			hv_hold <= 1'b0;
		else if (sync2[`OTFS_B_LLO])
			hv_hold <= 1'b1;
		else if (sync2[`OTFS_B_LHI])
			hv_hold <= 1'b0;
	end
	// registered outputs; controls and fault latch decoded from the next state, other status from code and level
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gate_drive_pin_en_out     <= 1'b0;
			probe_enable_out          <= 1'b0;
			low_power_out             <= 1'b0;
			supply_discharge_out      <= 1'b0;
			hv_source_on_out          <= 1'b0;
			fault_latched_out         <= 1'b0;
			program_resistor_code_out <= 4'h0;
			timer_level_out           <= 24'h00_0000;
		end else begin
			gate_drive_pin_en_out <= next_state == otfs_pkg::OTFS_RUN;
			probe_enable_out      <= next_state == otfs_pkg::OTFS_PROBE;
			low_power_out         <= next_state == otfs_pkg::OTFS_OFF
				|| next_state == otfs_pkg::OTFS_LATCH;
			supply_discharge_out  <= next_state == otfs_pkg::OTFS_DISCH;
			hv_source_on_out      <= next_state == otfs_pkg::OTFS_IDLE
				|| (next_state == otfs_pkg::OTFS_LATCH && hv_hold);
			fault_latched_out     <= next_state == otfs_pkg::OTFS_LATCH;
			program_resistor_code_out <= code;
			timer_level_out       <= level;
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_trip_run;
		state == otfs_pkg::OTFS_RUN && ovl_trip && !latch_f;
	endsequence
	sequence s_long_off;
		state == otfs_pkg::OTFS_OFF && !short_sel ##1 !gate_drive_pin_en_out;
	endsequence
	timer_trip_off_a: assert property (s_trip_run |=> s_long_off)
		else $error("timer trip did not start long off");
	timer_rises_a: assert property (tick && sq_in > level
		&& acc[33] == 1'b0 |=> level >= $past(level))
		else $error("timer level fell under larger input");
	setting_held_a: assert property (state == otfs_pkg::OTFS_RUN
		&& $past(state) == otfs_pkg::OTFS_RUN |-> $stable(code))
		else $error("setting changed while running");
	probe_no_gate_a: assert property (probe_enable_out
		|-> !gate_drive_pin_en_out)
		else $error("probe and drive together");
	startup_fault_a: assert property (probe_done && (raw_f
		|| sync2[`OTFS_B_PIN]) |=> state != otfs_pkg::OTFS_RUN
		##1 !gate_drive_pin_en_out)
		else $error("switching began with a fault present");
	short_off_a: assert property (state == otfs_pkg::OTFS_RUN
		&& short_f && !long_f && !latch_f |=> short_sel
		&& state == otfs_pkg::OTFS_OFF)
		else $error("line fault did not choose short off");
	latch_hv_a: assert property (state == otfs_pkg::OTFS_LATCH
		&& sync2[`OTFS_B_LLO] && sync2[`OTFS_B_LINE] |=> ##1 hv_source_on_out)
		else $error("hv source not on at lower latch level");
	line_loss_a: assert property (state == otfs_pkg::OTFS_LATCH
		&& !sync2[`OTFS_B_LINE] |=> state == otfs_pkg::OTFS_IDLE)
		else $error("latched fault survived line loss");
	ovp_stop_a: assert property (state == otfs_pkg::OTFS_RUN
		&& filt[`OTFS_B_OVP] |=> ##1 !gate_drive_pin_en_out)
		else $error("drive stayed on after supply over-voltage");
endmodule
